// *** rtl/pcp_device.sv ***
// device end of the parallel cpu port: target words, posted read fetch,
// local data and status registers, completion and data ready pins
// assumes pins synchronous to ref_clk_i and a host that keeps its rules
`timescale 1ns/10ps
`default_nettype none
module pcp_device
  import pcp_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  // pins
  pcp_if.dev        pins,
  // configuration straps
  input  wire logic three_wire_i,
  input  wire logic done_active_high_i,
  input  wire logic little_endian_i,
  // status
  output var  logic fetch_busy_o,
  output var  logic data_ready_o
);
  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_WAIT = 3'b010,
    ACC_HOLD = 3'b100
  } pcp_acc_type;

  pcp_acc_type       state_q;
  logic [CNT_W-1:0]  dcnt_q;
  logic [CNT_W-1:0]  fcnt_q;
  logic [IDX_W-1:0]  idx_q;
  logic              up_q;
  logic              is_rd_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0]        fetch_idx_q;
  logic              busy_q;
  logic              ready_q;
  logic [WORD_W-1:0] local_data_q;
  logic [WORD_W-1:0] mem_q [TGT_WORDS];
  logic              done_oe_q;
  logic              done_val_q;
  logic              data_oe_q;
  logic [DATA_W-1:0] data_q;

  logic              cs;
  logic              rd_act;
  logic              wr_act;
  logic              acc;
  logic [IDX_W-1:0]  idx;
  logic              up_sel;
  logic              act_lvl;
  logic              start_rd;
  logic              acc_end;
  logic              fetch_done;
  logic              rdy_release;
  logic [WORD_W-1:0] rword;

  assign cs = !pins.chip_select_l;
  // a read needs chip select and read strobe low with write select high;
  // in two-wire mode the strobe is held low by the host
  assign rd_act = cs && !pins.read_strobe_l && pins.write_select_l;
  // three-wire pairs chip select with each strobe; two-wire uses write select
  assign wr_act = cs && !pins.write_select_l
                  && (three_wire_i ? pins.read_strobe_l : 1'b1);
  assign acc = rd_act || wr_act;
  assign idx = pins.addr[ADDR_W-1:1];
  // big endian puts the upper half at the even address
  assign up_sel = (pins.addr[0] == 1'b0) ^ little_endian_i;
  assign act_lvl = done_active_high_i;
  assign start_rd = (state_q == ACC_IDLE) && rd_act;
  assign acc_end = (state_q != ACC_IDLE) && !acc;
  assign fetch_done = busy_q && (fcnt_q == CNT_W'(FETCH_CYC - 1));
  assign rdy_release = acc_end && is_rd_q
                       && ((idx_q == LD_IDX) || ((idx_q == LS_IDX) && !up_q));

  always_comb begin
    if (idx == LD_IDX) begin
      rword = local_data_q;
    end else if (idx == LS_IDX) begin
      rword = WORD_RST;
      rword[STAT_RDY_BIT] = ready_q;
      rword[STAT_BUSY_BIT] = busy_q;
    end else begin
      // target words are only reached through the posted fetch
      rword = WORD_RST;
    end
  end

  // access sequencing
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= ACC_IDLE;
      dcnt_q  <= '0;
      idx_q   <= '0;
      up_q    <= 1'b0;
      is_rd_q <= 1'b0;
    end else begin
      case (state_q)
        ACC_IDLE: begin
          if (acc) begin
            state_q <= ACC_WAIT;
            dcnt_q  <= '0;
            idx_q   <= idx;
            up_q    <= up_sel;
            is_rd_q <= rd_act;
          end
        end
        ACC_WAIT: begin
          if (!acc) begin
            state_q <= ACC_IDLE;
          end else if (dcnt_q == CNT_W'(DONE_CYC - 1)) begin
            state_q <= ACC_HOLD;
          end else begin
            dcnt_q <= dcnt_q + 1'b1;
          end
        end
        ACC_HOLD: begin
          if (!acc) begin
            state_q <= ACC_IDLE;
          end
        end
        default: state_q <= ACC_IDLE;
      endcase
    end
  end

  // completion pin: inactive on access start, active after the fixed delay,
  // released at the first clock edge that sees chip select high
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      done_oe_q  <= 1'b0;
      done_val_q <= 1'b1;
    end else begin
      if (!cs) begin
        done_oe_q <= 1'b0;
      end else if (state_q == ACC_IDLE && acc) begin
        done_oe_q <= 1'b1;
      end
      if (state_q == ACC_IDLE && acc) begin
        done_val_q <= !act_lvl;
      end else if (state_q == ACC_WAIT && acc && dcnt_q == CNT_W'(DONE_CYC - 1)) begin
        done_val_q <= act_lvl;
      end
    end
  end

  // read data pins
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      data_oe_q <= 1'b0;
      data_q    <= '0;
    end else begin
      // unused output enable is tied low by the host
      data_oe_q <= rd_act && !pins.read_output_enable_l;
      data_q    <= up_sel ? rword[WORD_W-1:DATA_W] : rword[DATA_W-1:0];
    end
  end

  // write halves land directly in the target word
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wdata_q <= '0;
      for (int i = 0; i < TGT_WORDS; i++) begin
        mem_q[i] <= WORD_RST;
      end
    end else begin
      if (acc) begin
        wdata_q <= pins.data_bus;
      end
      if (acc_end && !is_rd_q && idx_q < IDX_W'(TGT_WORDS)) begin
        if (up_q) begin
          mem_q[idx_q[3:0]][WORD_W-1:DATA_W] <= wdata_q;
        end else begin
          mem_q[idx_q[3:0]][DATA_W-1:0] <= wdata_q;
        end
      end
    end
  end

  // posted fetch into local data
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      busy_q       <= 1'b0;
      fcnt_q       <= '0;
      fetch_idx_q  <= '0;
      local_data_q <= WORD_RST;
    end else if (start_rd && idx < IDX_W'(TGT_WORDS)) begin
      busy_q      <= 1'b1;
      fcnt_q      <= '0;
      fetch_idx_q <= idx[3:0];
    end else if (fetch_done) begin
      busy_q       <= 1'b0;
      local_data_q <= mem_q[fetch_idx_q];
    end else if (busy_q) begin
      fcnt_q <= fcnt_q + 1'b1;
    end
  end

  // data ready: a finishing fetch wins over a release in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
    end else if (fetch_done) begin
      ready_q <= 1'b1;
    end else if (rdy_release) begin
      ready_q <= 1'b0;
    end
  end

  assign fetch_busy_o     = busy_q;
  assign data_ready_o     = ready_q;
  assign pins.dev_data    = data_q;
  assign pins.dev_data_oe = data_oe_q;
  assign pins.done_val    = done_val_q;
  assign pins.done_oe     = done_oe_q;
  assign pins.rdy_oe      = ready_q;
endmodule : pcp_device
`default_nettype wire

// *** rtl/pcp_host.sv ***
// host end of the parallel cpu port: turns 32-bit requests into half accesses
// assumes pins synchronous to ref_clk_i and a device that keeps its rules
`timescale 1ns/10ps
`default_nettype none
module pcp_host
  import pcp_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // pins
  pcp_if.host                    pins,
  // configuration
  input  wire logic              three_wire_i,
  input  wire logic              use_oe_i,
  input  wire logic              use_rdy_pin_i,
  input  wire logic              done_active_high_i,
  input  wire logic              little_endian_i,
  // requests
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [IDX_W-1:0]  req_idx_i,
  input  wire logic [WORD_W-1:0] req_wdata_i,
  output var  logic              req_ready_o,
  // answers
  output var  logic              rsp_valid_o,
  output var  logic [WORD_W-1:0] rsp_rdata_o
);
  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_PRE  = 6'b000010,
    H_SET  = 6'b000100,
    H_ACC  = 6'b001000,
    H_GAP  = 6'b010000,
    H_POLL = 6'b100000
  } pcp_host_type;

  pcp_host_type      state_q;
  logic              wr_q;
  logic [IDX_W-1:0]  idx_q;
  logic [WORD_W-1:0] wdata_q;
  logic [1:0]        step_q;
  logic [CNT_W-1:0]  cnt_q;
  logic [3:0]        rec_q;
  logic              first_q;
  logic              ready_q;
  logic              rsp_q;
  logic [WORD_W-1:0] rdata_q;
  logic              cs_l_q;
  logic              rd_l_q;
  logic              wr_l_q;
  logic              oe_l_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] dout_q;
  logic              doe_q;

  logic              rec_ok;
  logic [ADDR_W-1:0] nxt_addr;
  logic              nxt_up;
  logic              done_seen;

  // write recovery before the first half of the next request
  assign rec_ok = (step_q != 2'd0) || (wr_q ? rec_q >= 4'(WR_WR_CYC)
                                            : rec_q >= 4'(WR_RD_CYC));
  // read: target first, then both halves of local data
  assign nxt_addr = (!wr_q && step_q != 2'd0) ? {LD_IDX, step_q == 2'd2}
                                              : {idx_q, step_q == 2'd1};
  assign nxt_up = (nxt_addr[0] == 1'b0) ^ little_endian_i;
  assign done_seen = !first_q && (pins.access_complete == done_active_high_i);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_q <= H_IDLE;
      wr_q    <= 1'b0;
      idx_q   <= '0;
      wdata_q <= '0;
      step_q  <= 2'd0;
      cnt_q   <= '0;
      first_q <= 1'b0;
      rsp_q   <= 1'b0;
      rdata_q <= '0;
      cs_l_q  <= 1'b1;
      rd_l_q  <= 1'b1;
      wr_l_q  <= 1'b1;
      oe_l_q  <= 1'b1;
      addr_q  <= '0;
      dout_q  <= '0;
      doe_q   <= 1'b0;
    end else begin
      rsp_q <= 1'b0;
      case (state_q)
        H_IDLE: begin
          if (req_valid_i && ready_q) begin
            state_q <= H_PRE;
            wr_q    <= req_write_i;
            idx_q   <= req_idx_i;
            wdata_q <= req_wdata_i;
            step_q  <= 2'd0;
          end
        end
        H_PRE: begin
          // direction, strobes and address settle while chip select is high
          if (rec_ok) begin
            state_q <= H_SET;
            addr_q  <= nxt_addr;
            wr_l_q  <= !wr_q;
            rd_l_q  <= three_wire_i ? wr_q : 1'b0;
            oe_l_q  <= use_oe_i ? wr_q : 1'b0;
            dout_q  <= nxt_up ? wdata_q[WORD_W-1:DATA_W] : wdata_q[DATA_W-1:0];
            doe_q   <= wr_q;
          end
        end
        H_SET: begin
          state_q <= H_ACC;
          cs_l_q  <= 1'b0;
          first_q <= 1'b1;
        end
        H_ACC: begin
          // the completion wire is pulled up until the device drives it
          first_q <= 1'b0;
          if (done_seen) begin
            state_q <= H_GAP;
            cs_l_q  <= 1'b1;
            doe_q   <= 1'b0;
            cnt_q   <= '0;
            if (!wr_q && step_q != 2'd0) begin
              if (addr_q[0] ^ !little_endian_i) begin
                rdata_q[WORD_W-1:DATA_W] <= pins.data_bus;
              end else begin
                rdata_q[DATA_W-1:0] <= pins.data_bus;
              end
            end
          end
        end
        H_GAP: begin
          if (cnt_q >= CNT_W'(CS_GAP_CYC - 1)) begin
            cnt_q <= '0;
            if (wr_q && step_q == 2'd1) begin
              state_q <= H_IDLE;
            end else if (!wr_q && step_q == 2'd0) begin
              state_q <= H_POLL;
            end else if (!wr_q && step_q == 2'd2) begin
              state_q <= H_IDLE;
              rsp_q   <= 1'b1;
            end else begin
              state_q <= H_PRE;
              step_q  <= step_q + 2'd1;
            end
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        H_POLL: begin
          cnt_q <= cnt_q + 1'b1;
          if ((use_rdy_pin_i && !pins.posted_data_ready_l)
              || cnt_q == CNT_W'(RDY_WAIT_CYC - 1)) begin
            state_q <= H_PRE;
            step_q  <= 2'd1;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // cycles since the last write half ended, saturating
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rec_q <= 4'(WR_RD_CYC);
    end else if (state_q == H_ACC && done_seen && wr_q) begin
      rec_q <= '0;
    end else if (rec_q < 4'(WR_RD_CYC)) begin
      rec_q <= rec_q + 4'd1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (state_q == H_IDLE) && !(req_valid_i && ready_q);
    end
  end

  assign req_ready_o               = ready_q;
  assign rsp_valid_o               = rsp_q;
  assign rsp_rdata_o               = rdata_q;
  assign pins.chip_select_l        = cs_l_q;
  assign pins.read_strobe_l        = rd_l_q;
  assign pins.write_select_l       = wr_l_q;
  assign pins.read_output_enable_l = oe_l_q;
  assign pins.addr                 = addr_q;
  assign pins.host_data            = dout_q;
  assign pins.host_data_oe         = doe_q;
endmodule : pcp_host
`default_nettype wire

// *** rtl/pcp_if.sv ***
// pins of the parallel cpu port between host and device
// resolves the shared wires from the enables; undriven wires read as pulled up
`timescale 1ns/10ps
`default_nettype none
interface pcp_if;
  import pcp_pkg::*;
  logic              chip_select_l;
  logic              read_strobe_l;
  logic              write_select_l;
  logic              read_output_enable_l;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_data;
  logic              host_data_oe;
  logic [DATA_W-1:0] dev_data;
  logic              dev_data_oe;
  logic              done_val;
  logic              done_oe;
  logic              rdy_oe;
  logic [DATA_W-1:0] data_bus;
  logic              access_complete;
  logic              posted_data_ready_l;

  assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : 16'hffff);
  assign access_complete = done_oe ? done_val : 1'b1;
  assign posted_data_ready_l = !rdy_oe;

  modport dev (input chip_select_l, read_strobe_l, write_select_l, read_output_enable_l,
               input addr, data_bus,
               output dev_data, dev_data_oe, done_val, done_oe, rdy_oe);
  modport host (output chip_select_l, read_strobe_l, write_select_l, read_output_enable_l,
                output addr, host_data, host_data_oe,
                input data_bus, access_complete, posted_data_ready_l);
endinterface : pcp_if
`default_nettype wire

// *** rtl/pcp_pkg.sv ***
// constants shared by both ends of the parallel cpu port
// assumes one 40 MHz clock on both ends and pins that are synchronous to it
package pcp_pkg;
  localparam int CLK_NS      = 25;
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 16;
  localparam int WORD_W      = 32;
  localparam int IDX_W       = ADDR_W - 1;
  // address bit 0 picks the half, the rest is the word index
  localparam int TGT_WORDS   = 16;
  localparam logic [IDX_W-1:0] LD_IDX = 7'h40;
  localparam logic [IDX_W-1:0] LS_IDX = 7'h41;
  localparam int STAT_RDY_BIT  = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  // timing, least times and the ready wait round up, completion and fetch times round down
  localparam int CS_GAP_NS   = 18;
  localparam int WR_WR_NS    = 130;
  localparam int WR_RD_NS    = 250;
  localparam int RDY_MAX_NS  = 1000;
  localparam int DONE_MAX_NS = 43;
  localparam int FETCH_NS    = 200;
  localparam int CS_GAP_CYC  = (CS_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_WR_CYC   = (WR_WR_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_RD_CYC   = (WR_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RDY_WAIT_CYC = (RDY_MAX_NS + CLK_NS - 1) / CLK_NS;
  localparam int DONE_CYC    = (DONE_MAX_NS / CLK_NS) < 1 ? 1 : DONE_MAX_NS / CLK_NS;
  localparam int FETCH_CYC   = (FETCH_NS / CLK_NS) < 1 ? 1 : FETCH_NS / CLK_NS;
  localparam int CNT_W       = 6;
endpackage : pcp_pkg

// *** testbench/parallel_cpu_port_tb_top.sv ***
// self-checking bench: host and device ends joined by the pin interface
// drives the host request side and the straps, checks answers and the write halves
`timescale 1ns/10ps
`default_nettype none
module parallel_cpu_port_tb_top;
  import pcp_pkg::*;
  logic                      ref_clk;
  logic                      rst;
  logic                      three_wire, done_ah, little_end, use_oe, use_rdy;
  logic                      req_valid, req_write, req_ready, rsp_valid;
  logic                      fetch_busy, data_ready, cs_prev, wr_prev;
  logic [IDX_W-1:0]          req_idx;
  logic [WORD_W-1:0]         req_wdata, rsp_rdata;
  logic [ADDR_W-1:0]         wa_q;
  logic [DATA_W-1:0]         wd_q;
  logic [ADDR_W+DATA_W-1:0]  wlog [$];
  int                        error_cnt, total_checks;

  pcp_if pcp_if_inst ();
  pcp_device pcp_device_inst (.ref_clk_i(ref_clk), .rst_i(rst), .pins(pcp_if_inst),
    .three_wire_i(three_wire), .done_active_high_i(done_ah), .little_endian_i(little_end),
    .fetch_busy_o(fetch_busy), .data_ready_o(data_ready));
  pcp_host pcp_host_inst (.ref_clk_i(ref_clk), .rst_i(rst), .pins(pcp_if_inst),
    .three_wire_i(three_wire), .use_oe_i(use_oe), .use_rdy_pin_i(use_rdy),
    .done_active_high_i(done_ah), .little_endian_i(little_end), .req_valid_i(req_valid),
    .req_write_i(req_write), .req_idx_i(req_idx), .req_wdata_i(req_wdata),
    .req_ready_o(req_ready), .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata));
  pcp_properties pcp_properties_inst (.ref_clk_i(ref_clk), .rst_i(rst),
    .chip_select_l(pcp_if_inst.chip_select_l), .read_strobe_l(pcp_if_inst.read_strobe_l),
    .write_select_l(pcp_if_inst.write_select_l), .addr(pcp_if_inst.addr),
    .read_output_enable_l(pcp_if_inst.read_output_enable_l),
    .host_data_oe(pcp_if_inst.host_data_oe), .dev_data_oe(pcp_if_inst.dev_data_oe),
    .done_oe(pcp_if_inst.done_oe), .access_complete(pcp_if_inst.access_complete),
    .posted_data_ready_l(pcp_if_inst.posted_data_ready_l), .three_wire_i(three_wire),
    .done_active_high_i(done_ah), .use_oe_i(use_oe));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // logs each write half as the wire shows it in the last active cycle
  always @(negedge ref_clk) begin
    if (!pcp_if_inst.chip_select_l && !pcp_if_inst.write_select_l) begin
      wa_q = pcp_if_inst.addr;
      wd_q = pcp_if_inst.data_bus;
    end
    if (pcp_if_inst.chip_select_l && !cs_prev && !wr_prev) wlog.push_back({wa_q, wd_q});
    cs_prev = pcp_if_inst.chip_select_l;
    wr_prev = pcp_if_inst.write_select_l;
  end

  task automatic check_word(input string what, input logic [WORD_W-1:0] exp,
                            input logic [WORD_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check_word

  task automatic check_bit(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // straps change only while reset is held, as the ends expect them static
  task automatic do_reset(input logic [4:0] cfg);
    @(negedge ref_clk);
    {three_wire, done_ah, little_end, use_oe, use_rdy} = cfg;
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
  endtask : do_reset

  task automatic host_op(input logic wr, input logic [IDX_W-1:0] idx,
                         input logic [WORD_W-1:0] wdata, output logic [WORD_W-1:0] rdata);
    int n;
    n = 0;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_write = wr;
    req_idx = idx;
    req_wdata = wdata;
    // ready is looked at mid-cycle, so the edge after a high sample takes the request
    while (req_ready !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    req_valid = 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
    end while ((wr ? req_ready : rsp_valid) !== 1'b1 && n < 400);
    rdata = rsp_rdata;
    if (n >= 400) begin
      error_cnt++;
      $display("MISMATCH host answer expected in time seen none");
    end
  endtask : host_op

  task automatic write_word(input logic [IDX_W-1:0] idx, input logic [WORD_W-1:0] w);
    logic [WORD_W-1:0] unused;
    wlog.delete();
    host_op(1'b1, idx, w, unused);
    check_word("write halves", 32'h2, 32'(wlog.size()));
    if (wlog.size() == 2) begin
      check_word("first half", {8'h00, idx, 1'b0, little_end ? w[15:0] : w[31:16]},
                 {8'h00, wlog[0]});
      check_word("second half", {8'h00, idx, 1'b1, little_end ? w[31:16] : w[15:0]},
                 {8'h00, wlog[1]});
    end
  endtask : write_word

  task automatic read_word(input logic [IDX_W-1:0] idx, input logic [WORD_W-1:0] exp);
    logic [WORD_W-1:0] got;
    host_op(1'b0, idx, 32'h0, got);
    check_word("read word", exp, got);
    check_bit("ready released", 1'b0, data_ready);
    check_bit("fetch idle", 1'b0, fetch_busy);
  endtask : read_word

  // every mode, polarity, endianness and enable choice, edge word indices
  task automatic t_modes();
    logic [4:0] cfg [4] = '{5'h03, 5'h1c, 5'h0d, 5'h12};
    for (int i = 0; i < 4; i++) begin
      do_reset(cfg[i]);
      write_word(IDX_W'(i * 5), 32'ha5c3_0f00 + 32'(i));
      read_word(IDX_W'(i * 5), 32'ha5c3_0f00 + 32'(i));
      read_word(7'h01, WORD_RST);
    end
    $display("test t_modes done");
  endtask : t_modes

  task automatic t_back_to_back();
    do_reset(5'h12);
    write_word(7'h02, 32'hffff_0000);
    write_word(7'h03, 32'h0000_ffff);
    read_word(7'h03, 32'h0000_ffff);
    read_word(7'h02, 32'hffff_0000);
    $display("test t_back_to_back done");
  endtask : t_back_to_back

  // an index past the target words must not alias onto a real one
  task automatic t_unmapped();
    do_reset(5'h0d);
    write_word(7'h00, 32'h0102_0304);
    write_word(7'h10, 32'hdead_beef);
    read_word(7'h00, 32'h0102_0304);
    $display("test t_unmapped done");
  endtask : t_unmapped

  initial begin
    rst = 1'b1;
    {three_wire, done_ah, little_end, use_oe, use_rdy} = 5'h03;
    {req_valid, req_write, req_idx, req_wdata} = '0;
    {cs_prev, wr_prev} = 2'h3;
    error_cnt = 0;
    total_checks = 0;
    t_modes();
    t_back_to_back();
    t_unmapped();
    final_report();
  end

  // the tests need under a thousand cycles, so five thousand means a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    $display("MISMATCH run length expected under 5000 cycles seen more");
    final_report();
  end
endmodule : parallel_cpu_port_tb_top
`default_nettype wire

// *** testbench/pcp_properties.sv ***
// concurrent checks on the pins between the host and device ends of the cpu port
// assumes the interface signals and the mode straps, all on ref_clk_i
`timescale 1ns/10ps
`default_nettype none
module pcp_properties
  import pcp_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  // host driven pins
  input  wire logic              chip_select_l,
  input  wire logic              read_strobe_l,
  input  wire logic              write_select_l,
  input  wire logic              read_output_enable_l,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              host_data_oe,
  // device driven pins
  input  wire logic              dev_data_oe,
  input  wire logic              done_oe,
  input  wire logic              access_complete,
  input  wire logic              posted_data_ready_l,
  // mode straps
  input  wire logic              three_wire_i,
  input  wire logic              done_active_high_i,
  input  wire logic              use_oe_i
);
  localparam int RDY_LIM = 40;
  logic       rd_now;
  logic       wr2_seen_q;
  logic [5:0] gap_q;

  assign rd_now = !chip_select_l && !read_strobe_l && write_select_l;

  // chip select high run length, saturating so long idle spells never wrap
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !chip_select_l) begin
      gap_q <= 6'h00;
    end else if (gap_q != 6'h3f) begin
      gap_q <= gap_q + 6'h01;
    end
  end

  // remembers whether the last access was the closing half of a write
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      wr2_seen_q <= 1'b0;
    end else if (!chip_select_l) begin
      wr2_seen_q <= !write_select_l && addr[0];
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_data_gate: assert property (dev_data_oe |-> $past(rd_now && !read_output_enable_l))
    else $error("device drives data outside an enabled read");
  a_data_follow: assert property ((rd_now && !read_output_enable_l) |=> dev_data_oe)
    else $error("device does not drive data during an enabled read");
  a_no_clash: assert property (!(dev_data_oe && host_data_oe))
    else $error("both ends drive the data bus");
  a_done_order: assert property ($fell(chip_select_l) |=>
    (done_oe && access_complete == !done_active_high_i) ##1 access_complete == done_active_high_i)
    else $error("completion not inactive then active after select");
  a_done_release: assert property ($rose(chip_select_l) |=> !done_oe)
    else $error("completion still driven after select released");
  a_hold_to_done: assert property ($rose(chip_select_l) |->
    $past(access_complete == done_active_high_i))
    else $error("select released before completion");
  a_done_holds: assert property ((!chip_select_l && done_oe &&
    access_complete == done_active_high_i) |=> access_complete == done_active_high_i)
    else $error("completion dropped while select held");
  a_ready_timely: assert property (($fell(chip_select_l) && rd_now &&
    addr[7:1] < TGT_WORDS) |-> ##[1:RDY_LIM] !posted_data_ready_l)
    else $error("data ready late after posted read");
  a_ready_release: assert property (($rose(chip_select_l) &&
    $past(rd_now && addr[7:1] == LD_IDX)) |=> posted_data_ready_l)
    else $error("data ready kept after local data read");
  a_write_recovery: assert property (($fell(chip_select_l) && wr2_seen_q) |->
    gap_q >= (write_select_l ? WR_RD_CYC : WR_WR_CYC))
    else $error("access too soon after a write");
  a_strobe_two_wire: assert property ((!three_wire_i && !chip_select_l) |->
    !read_strobe_l)
    else $error("read strobe high in two-wire access");
  a_oe_tied: assert property ((!use_oe_i && !chip_select_l) |-> !read_output_enable_l)
    else $error("unused output enable not low");
  a_dir_stable: assert property ((!three_wire_i && !chip_select_l &&
    !$past(chip_select_l)) |-> $stable(write_select_l))
    else $error("direction changed during access");

  c_read_3w: cover property ($fell(chip_select_l) && rd_now && three_wire_i);
  c_write: cover property ($fell(chip_select_l) && !write_select_l);
  c_ready: cover property ($fell(posted_data_ready_l));
  c_recover: cover property ($fell(chip_select_l) && wr2_seen_q && write_select_l);
endmodule : pcp_properties
`default_nettype wire
